//--- logic/vscc_top.sv
`timescale 1ns/1ps
module vscc_top
	import vscc_pkg::*;
#(
	parameter int TERM_CYC = TERM_PULSE_CYC
) (
	// clocks and reset
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic LINK_CLK,
	// serial bus
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N,
	// parallel control pins
	input wire logic PIN_SOURCE_SEL_LSB,
	input wire logic PIN_SOURCE_SEL_MSB,
	input wire logic PIN_GLOBAL_BOOST,
	input wire logic PIN_OUT_TERM_ENABLE,
	input wire logic PIN_OUT_DRIVE_ENABLE,
	input wire logic PIN_OUT_CURRENT_LEVEL,
	input wire logic [1:0] PIN_EMPHASIS_BUS,
	input wire logic ADDR_STRAP_0,
	input wire logic ADDR_STRAP_1,
	input wire logic ADDR_STRAP_2,
	// status
	output logic SERIAL_MODE,
	// link side settings, on LINK_CLK
	output logic [1:0] SRC_SEL,
	output logic [15:0] IN_TERM_OFF,
	output logic [7:0] IN_BOOST_HI,
	output logic OUT_TERM_EN,
	output logic OUT_DRIVE_EN,
	output logic OUT_CUR_HI,
	output logic [1:0] OUT_EMPH
);
	logic [1:0] bus_q;
	logic [10:0] pin_q;
	logic scl;
	logic sda;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic [1:0] pin_src;
	logic pin_boost;
	logic pin_term;
	logic pin_drive;
	logic pin_cur;
	logic [1:0] pin_emph;
	logic [6:0] dev_addr;

	vscc_sync3 #(
		.W(2),
		.RST_VAL(2'h3)
	) u_bus_sync (
		.clk(CLK),
		.rst_n(RST_N),
		.d({SCL_IN, SDA_IN}),
		.q(bus_q)
	);

	vscc_sync3 #(
		.W(11)
	) u_pin_sync (
		.clk(CLK),
		.rst_n(RST_N),
		.d({PIN_SOURCE_SEL_MSB, PIN_SOURCE_SEL_LSB, PIN_GLOBAL_BOOST, PIN_OUT_TERM_ENABLE,
			PIN_OUT_DRIVE_ENABLE, PIN_OUT_CURRENT_LEVEL, PIN_EMPHASIS_BUS,
			ADDR_STRAP_2, ADDR_STRAP_1, ADDR_STRAP_0}),
		.q(pin_q)
	);

	assign scl = bus_q[1];
	assign sda = bus_q[0];
	assign pin_src = pin_q[10:9]; // [RL17]
	assign pin_boost = pin_q[8];
	assign pin_term = pin_q[7];
	assign pin_drive = pin_q[6];
	assign pin_cur = pin_q[5];
	assign pin_emph = pin_q[4:3];
	assign dev_addr = {ADDR_HI, pin_q[2:0]}; // [RL18] [RL4]

	// bus events from the filtered lines
	assign scl_rise = scl & ~scl_q;
	assign scl_fall = ~scl & scl_q;
	assign start_ev = scl & scl_q & sda_q & ~sda;
	assign stop_ev = scl & scl_q & ~sda_q & sda;

	// serial slave and register bank
	vscc_state_t state;
	vscc_state_t next_state;
	vscc_state_t after;
	vscc_state_t next_after;
	logic [7:0] sh;
	logic [7:0] next_sh;
	logic [3:0] bitcnt;
	logic [3:0] next_bitcnt;
	logic [7:0] ptr;
	logic [7:0] next_ptr;
	logic serial_mode;
	logic next_serial_mode;
	logic next_sda_oe_n;
	logic [1:0] reg_src;
	logic [1:0] next_src;
	logic [15:0] reg_pulse;
	logic [15:0] next_pulse;
	logic [7:0] reg_boost;
	logic [7:0] next_boost;
	logic [7:0] reg_tx;
	logic [7:0] next_tx;
	logic [7:0] reg_modes;
	logic [7:0] next_modes;
	logic [7:0] rd_data;
	logic load_rd;

	// read mux; unmapped offsets read as zero
	always_comb begin
		case (ptr)
			REG_SRC: rd_data = {6'h00, reg_src};
			REG_PULSE_LO: rd_data = reg_pulse[7:0];
			REG_PULSE_HI: rd_data = reg_pulse[15:8];
			REG_BOOST: rd_data = reg_boost;
			REG_TX: rd_data = reg_tx;
			REG_MODES: rd_data = reg_modes;
			default: rd_data = 8'h00;
		endcase
	end

	always_comb begin
		next_state = state;
		next_after = after;
		next_sh = sh;
		next_bitcnt = bitcnt;
		next_ptr = ptr;
		next_serial_mode = serial_mode;
		next_sda_oe_n = SDA_OE_N;
		next_src = reg_src;
		next_pulse = reg_pulse;
		next_boost = reg_boost;
		next_tx = reg_tx;
		next_modes = reg_modes;
		load_rd = 1'b0;
		// registers mirror the pins until the first access to the device's own address
		if (!serial_mode) begin // [RL2] [RL20]
			next_src = pin_src; // [RL17]
			next_pulse = PULSE_RST; // [RL6]
			next_boost = {8{pin_boost}}; // [RL8]
			next_tx = TX_RST;
			next_tx[TX_TERM_BIT] = pin_term; // [RL9] [RL10]
			next_tx[TX_CUR_BIT] = pin_cur; // [RL14]
			next_tx[TX_EMPH_LSB +: 2] = pin_emph; // [RL16]
			next_modes = MODES_RST;
			next_modes[MODES_DRV_BIT] = pin_drive; // [RL11]
		end
		if (start_ev) begin
			next_state = ST_ADDR;
			next_bitcnt = 4'h0;
			next_sda_oe_n = 1'b1;
		end else if (stop_ev) begin
			next_state = ST_IDLE;
			next_sda_oe_n = 1'b1;
		end else begin
			case (state)
				ST_IDLE: begin
					next_bitcnt = 4'h0;
				end
				ST_ADDR, ST_REG, ST_WDAT: begin
					if (scl_rise && bitcnt < BYTE_BITS) begin
						next_sh = {sh[6:0], sda};
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == BYTE_BITS) begin
						next_bitcnt = 4'h0;
						next_state = ST_ACK;
						next_sda_oe_n = 1'b0;
						if (state == ST_ADDR) begin
							if (sh[7:1] == dev_addr) begin // [RL4] [RL18]
								next_serial_mode = 1'b1; // [RL20] [RL2]
								next_after = sh[0] ? ST_RDAT : ST_REG;
							end else begin
								next_state = ST_IDLE;
								next_sda_oe_n = 1'b1;
							end
						end else if (state == ST_REG) begin
							next_ptr = sh;
							next_after = ST_WDAT;
						end else begin
							next_after = ST_WDAT;
							next_ptr = ptr + 8'h01;
							case (ptr)
								REG_SRC: next_src = sh[1:0]; // [RL1]
								REG_PULSE_LO: next_pulse[7:0] = sh; // [RL5]
								REG_PULSE_HI: next_pulse[15:8] = sh; // [RL5]
								REG_BOOST: next_boost = sh; // [RL7]
								REG_TX: next_tx = sh; // [RL9] [RL16]
								REG_MODES: next_modes = sh; // [RL11]
								default: next_ptr = ptr + 8'h01;
							endcase
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						next_sda_oe_n = 1'b1;
						next_state = after;
						load_rd = (after == ST_RDAT);
					end
				end
				ST_RDAT: begin
					if (scl_rise) begin
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall) begin
						if (bitcnt == BYTE_BITS) begin
							next_sda_oe_n = 1'b1;
							next_bitcnt = 4'h0;
							next_state = ST_RACK;
						end else begin
							next_sda_oe_n = sh[7];
							next_sh = {sh[6:0], 1'b0};
						end
					end
				end
				ST_RACK: begin
					if (scl_rise && sda) begin
						next_state = ST_IDLE;
					end else if (scl_fall) begin
						next_state = ST_RDAT;
						load_rd = 1'b1;
					end
				end
				default: begin
					next_state = ST_IDLE;
					next_sda_oe_n = 1'b1;
				end
			endcase
		end
		// first data bit goes out on the fall closing the acknowledge
		if (load_rd) begin
			next_sda_oe_n = rd_data[7];
			next_sh = {rd_data[6:0], 1'b0};
			next_bitcnt = 4'h0;
			next_ptr = ptr + 8'h01;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin // [RL3] [RL19]
			state <= ST_IDLE;
			after <= ST_IDLE;
			sh <= 8'h00;
			bitcnt <= 4'h0;
			ptr <= 8'h00;
			serial_mode <= 1'b0;
			SDA_OE_N <= 1'b1;
			SDA_OUT <= 1'b0;
			SERIAL_MODE <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			reg_src <= SRC_RST;
			reg_pulse <= PULSE_RST;
			reg_boost <= BOOST_RST;
			reg_tx <= TX_RST;
			reg_modes <= MODES_RST;
		end else begin
			state <= next_state;
			after <= next_after;
			sh <= next_sh;
			bitcnt <= next_bitcnt;
			ptr <= next_ptr;
			serial_mode <= next_serial_mode;
			SDA_OE_N <= next_sda_oe_n;
			SDA_OUT <= 1'b0;
			SERIAL_MODE <= next_serial_mode;
			scl_q <= scl;
			sda_q <= sda;
			reg_src <= next_src;
			reg_pulse <= next_pulse;
			reg_boost <= next_boost;
			reg_tx <= next_tx;
			reg_modes <= next_modes;
		end
	end

	// termination pulse after a source change
	logic [1:0] src_q;
	logic [31:0] tmr;
	logic [31:0] next_tmr;
	logic src_chg;
	logic [15:0] term_off;

	assign src_chg = reg_src != src_q;
	assign term_off = (tmr != 32'h0) ? reg_pulse : 16'h0000; // [RL5] [RL6]

	always_comb begin
		next_tmr = tmr;
		if (serial_mode && src_chg) begin // [RL5]
			next_tmr = 32'(TERM_CYC);
		end else if (tmr != 32'h0) begin
			next_tmr = tmr - 32'h1;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			src_q <= SRC_RST;
			tmr <= 32'h0;
		end else begin
			src_q <= reg_src;
			tmr <= next_tmr;
		end
	end

	// settings word carried to the link clock
	logic [WORD_W-1:0] word;
	logic [WORD_W-1:0] link_word;

	assign word = {reg_src, term_off, reg_boost, reg_tx[TX_TERM_BIT], reg_modes[MODES_DRV_BIT],
		reg_tx[TX_CUR_BIT], reg_tx[TX_EMPH_LSB +: 2]};

	vscc_xfer #(
		.W(WORD_W)
	) u_xfer (
		.clk(CLK),
		.rst_n(RST_N),
		.d(word),
		.lclk(LINK_CLK),
		.q(link_word)
	);

	assign SRC_SEL = link_word[30:29];
	assign IN_TERM_OFF = link_word[28:13];
	assign IN_BOOST_HI = link_word[12:5];
	assign OUT_TERM_EN = link_word[4];
	assign OUT_DRIVE_EN = link_word[3];
	assign OUT_CUR_HI = link_word[2];
	assign OUT_EMPH = link_word[1:0];

	a_serial_sticky: assert property (@(posedge CLK) disable iff (!RST_N) // [RL20]
		serial_mode |=> serial_mode)
		else $error("serial flag dropped");

	a_pins_ignored: assert property (@(posedge CLK) disable iff (!RST_N) // [RL2]
		(serial_mode && state == ST_IDLE && $changed(pin_q[8:3])) |=> $stable(reg_boost) && $stable(reg_tx))
		else $error("pins changed settings in serial mode");

	a_par_boost: assert property (@(posedge CLK) disable iff (!RST_N) // [RL8]
		(!serial_mode && $stable(pin_boost)) |=> reg_boost == {8{$past(pin_boost)}})
		else $error("global boost not applied");

	a_par_no_pulse: assert property (@(posedge CLK) disable iff (!RST_N) // [RL6]
		!serial_mode |-> term_off == 16'h0000 && tmr == 32'h0)
		else $error("termination pulsed under pin control");

	a_pulse_start: assert property (@(posedge CLK) disable iff (!RST_N) // [RL5]
		(serial_mode && src_chg) |=> tmr == 32'(TERM_CYC) && term_off == reg_pulse)
		else $error("termination pulse not started");

	a_addr_ack: assert property (@(posedge CLK) disable iff (!RST_N) // [RL4]
		(state == ST_ADDR && scl_fall && bitcnt == BYTE_BITS && sh[7:1] == dev_addr && !start_ev && !stop_ev)
		|=> !SDA_OE_N && serial_mode && state == ST_ACK)
		else $error("own address not acknowledged");

	a_addr_foreign: assert property (@(posedge CLK) disable iff (!RST_N) // [RL18]
		(state == ST_ADDR && scl_fall && bitcnt == BYTE_BITS && sh[7:1] != dev_addr && !start_ev && !stop_ev)
		|=> SDA_OE_N && state == ST_IDLE && serial_mode == $past(serial_mode))
		else $error("foreign address answered");

	a_tx_write: assert property (@(posedge CLK) disable iff (!RST_N) // [RL9]
		(state == ST_WDAT && ptr == REG_TX && scl_fall && bitcnt == BYTE_BITS && !start_ev && !stop_ev)
		|=> reg_tx == $past(sh) ##1 reg_tx[TX_TERM_BIT] == $past(reg_tx[TX_TERM_BIT]))
		else $error("transmitter settings not written");

	a_par_term: assert property (@(posedge CLK) disable iff (!RST_N) // [RL10]
		(!serial_mode && $stable(pin_term) && $stable(pin_cur)) |=>
		reg_tx[TX_TERM_BIT] == $past(pin_term) && reg_tx[TX_CUR_BIT] == $past(pin_cur))
		else $error("termination or current not following pins");
endmodule : vscc_top

//--- inc/vscc_pkg.sv
// Functional notes
// (RL1) One of four input links, four channels each, drives the single output link.
// (RL2) After any serial access, register values win and pins are ignored until reset; the code switches over only on an access to its own address.
// (RL3) Reset returns every control register to its default.
// (RL4) Serial slave answers one of eight strap-selected bus addresses.
// (RL5) Enabled input channels drop termination about 100 ms after a source change.
// (RL6) Under pin control all input terminations stay connected, no pulsing.
// (RL7) Serial control sets 6 dB or 12 dB boost per input channel.
// (RL8) Under pin control one pin sets the same boost for every channel.
// (RL9) Output termination follows its register bit (serial) or its pin (parallel).
// (RL10) After reset the output termination setting follows its pin.
// (RL11) Output drivers tristate by register bit (serial) or pin (parallel).
// (RL12) Controller picks 20 mA when internal and external terminations coexist.
// (RL13) Controller picks 10 mA when only external terminations exist.
// (RL14) After reset the output current level follows its pin.
// (RL15) Controller keeps outputs disabled when no termination exists.
// (RL16) Pre-emphasis picks one of four levels from register field or two pins.
// (RL17) Parallel source select is a two-pin code, low pin is the LSB.
// (RL18) Slave address is fixed upper nibble plus three strap bits.
// (RL19) Low reset restores defaults; the system holds it high otherwise.
// (RL20) Sticky serial flag set by first addressed access, cleared only by reset.
package vscc_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int TERM_PULSE_MS = 100;
	localparam int TERM_PULSE_CYC = (CLK_HZ / 1000) * TERM_PULSE_MS;
	localparam logic [3:0] ADDR_HI = 4'h9;
	// register offsets
	localparam logic [7:0] REG_SRC = 8'h00;
	localparam logic [7:0] REG_PULSE_LO = 8'h01;
	localparam logic [7:0] REG_PULSE_HI = 8'h02;
	localparam logic [7:0] REG_BOOST = 8'h03;
	localparam logic [7:0] REG_TX = 8'h04;
	localparam logic [7:0] REG_MODES = 8'h05;
	// field positions
	localparam int TX_TERM_BIT = 0;
	localparam int TX_CUR_BIT = 1;
	localparam int TX_EMPH_LSB = 2;
	localparam int MODES_DRV_BIT = 0;
	// reset values
	localparam logic [1:0] SRC_RST = 2'h0;
	localparam logic [15:0] PULSE_RST = 16'h0000;
	localparam logic [7:0] BOOST_RST = 8'h00;
	localparam logic [7:0] TX_RST = 8'h00;
	localparam logic [7:0] MODES_RST = 8'h00;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int WORD_W = 31;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_REG = 7'h04,
		ST_WDAT = 7'h08,
		ST_ACK = 7'h10,
		ST_RDAT = 7'h20,
		ST_RACK = 7'h40
	} vscc_state_t;
endpackage : vscc_pkg

//--- logic/vscc_sync3.sv
`timescale 1ns/1ps
module vscc_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// asynchronous inputs and filtered result
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_q;

	// a bit moves only once the second and third stages agree
	always_comb begin
		next_q = (s2 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			q <= RST_VAL;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q <= next_q;
		end
	end
endmodule : vscc_sync3

//--- logic/vscc_xfer.sv
`timescale 1ns/1ps
module vscc_xfer #(
	parameter int W = 8
) (
	// source side
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	// link side
	input wire logic lclk,
	output logic [W-1:0] q
);
	logic [W-1:0] held;
	logic [W-1:0] next_held;
	logic req;
	logic next_req;
	logic a1;
	logic a2;
	logic r1;
	logic r2;
	logic r3;
	logic [W-1:0] next_q;

	// new word launched only after the previous one was acknowledged
	always_comb begin
		next_held = held;
		next_req = req;
		if (req == a2 && d != held) begin
			next_held = d;
			next_req = ~req;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			held <= '0;
			req <= 1'b0;
			a1 <= 1'b0;
			a2 <= 1'b0;
		end else begin
			held <= next_held;
			req <= next_req;
			a1 <= r3;
			a2 <= a1;
		end
	end

	// held is stable while the request toggle is in flight
	always_comb begin
		next_q = q;
		if (r2 != r3) begin
			next_q = held;
		end
	end

	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			r1 <= 1'b0;
			r2 <= 1'b0;
			r3 <= 1'b0;
			q <= '0;
		end else begin
			r1 <= req;
			r2 <= r1;
			r3 <= r2;
			q <= next_q;
		end
	end

	a_link_capture: assert property (@(posedge lclk) disable iff (!rst_n) // [RL1]
		(r2 != r3) |=> (q == $past(held)))
		else $error("link word not captured");
endmodule : vscc_xfer

//--- sim/vscc_master.sv
`timescale 1ns/1ps
module vscc_master (
	// bus clock and device answer
	input wire logic clk,
	input wire logic sda_oe_n,
	input wire logic sda_out,
	// bus lines
	output logic scl,
	output logic sda_line
);
	logic sda_drv = 1'h1;
	initial scl = 1'h1;
	// pull-up: line low only while a party pulls it low
	assign sda_line = sda_drv & (sda_oe_n | sda_out);
	task automatic q;
		repeat (13) @(posedge clk);
		#2;
	endtask : q
	task automatic bitx(input logic b, output logic r);
		sda_drv = b;
		q();
		scl = 1'h1;
		q();
		r = sda_line;
		q();
		scl = 1'h0;
		q();
	endtask : bitx
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'h1, r);
		ack = ~r;
	endtask : wbyte
	// start, address, register, up to three data bytes, stop
	task automatic wr(input logic [6:0] a, input logic [7:0] r, input int n, input logic [23:0] d, output logic ok);
		logic k;
		sda_drv = 1'h0;
		q();
		scl = 1'h0;
		q();
		wbyte({a, 1'h0}, ok);
		if (ok) begin
			wbyte(r, k);
			for (int i = 0; i < n; i++) wbyte(d[8*i +: 8], k);
		end
		sda_drv = 1'h0;
		q();
		scl = 1'h1;
		q();
		sda_drv = 1'h1;
		q();
	endtask : wr
	// start, address, register, repeated start, one read byte closed by a nack, stop
	task automatic rd(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d, output logic ok);
		logic k;
		logic b;
		sda_drv = 1'h0;
		q();
		scl = 1'h0;
		q();
		wbyte({a, 1'h0}, ok);
		wbyte(r, k);
		sda_drv = 1'h1;
		q();
		scl = 1'h1;
		q();
		sda_drv = 1'h0;
		q();
		scl = 1'h0;
		q();
		wbyte({a, 1'h1}, k);
		ok = ok & k;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'h1, b);
			d[i] = b;
		end
		bitx(1'h1, b);
		sda_drv = 1'h0;
		q();
		scl = 1'h1;
		q();
		sda_drv = 1'h1;
		q();
	endtask : rd
endmodule : vscc_master

//--- sim/video_switch_config_control_tb.sv
`timescale 1ns/1ps
module video_switch_config_control_tb;
	import vscc_pkg::*;
	localparam int TC = 200;
	logic clk, rst_n, link_clk, scl, sda, sda_out, sda_oe_n, serial_mode, ok;
	logic out_term_en, out_drive_en, out_cur_hi;
	logic [7:0] pins, v, in_boost_hi, rdat;
	logic [6:0] a;
	logic [2:0] strap;
	logic [1:0] src_sel, out_emph, ns;
	logic [15:0] in_term_off, seed, mask;
	logic [23:0] tx;
	int mismatches, checks, cyc;

	vscc_top #(.TERM_CYC(TC)) uut (.CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .PIN_SOURCE_SEL_LSB(pins[0]), .PIN_SOURCE_SEL_MSB(pins[1]),
		.PIN_GLOBAL_BOOST(pins[2]), .PIN_OUT_TERM_ENABLE(pins[3]), .PIN_OUT_DRIVE_ENABLE(pins[4]),
		.PIN_OUT_CURRENT_LEVEL(pins[5]), .PIN_EMPHASIS_BUS(pins[7:6]), .ADDR_STRAP_0(strap[0]),
		.ADDR_STRAP_1(strap[1]), .ADDR_STRAP_2(strap[2]), .SERIAL_MODE(serial_mode), .SRC_SEL(src_sel),
		.IN_TERM_OFF(in_term_off), .IN_BOOST_HI(in_boost_hi), .OUT_TERM_EN(out_term_en),
		.OUT_DRIVE_EN(out_drive_en), .OUT_CUR_HI(out_cur_hi), .OUT_EMPH(out_emph));
	vscc_master mst (.clk(clk), .sda_oe_n(sda_oe_n), .sda_out(sda_out), .scl(scl), .sda_line(sda));

	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial begin
		link_clk = 1'h0;
		#7;
		forever #80 link_clk = ~link_clk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// emphasis, current, drive, termination, boost, source from a pin byte
	function automatic logic [7:0] pin_rand(input logic [15:0] s, input logic [2:0] i);
		logic [7:0] r;
		r = {i[2:1], s[3], s[4:2], i[1:0]};
		return r;
	endfunction : pin_rand

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : wait_clk
	task automatic chk_pins(input logic [7:0] p);
		chk("src", {14'h0, p[1:0]}, {14'h0, src_sel});
		chk("boost", {8'h0, {8{p[2]}}}, {8'h0, in_boost_hi});
		chk("oterm", p[3], out_term_en);
		chk("drive", p[4], out_drive_en);
		chk("cur", p[5], out_cur_hi);
		chk("emph", p[7:6], out_emph);
		chk("iterm", 16'h0, in_term_off);
	endtask : chk_pins
	task automatic do_reset(input logic [7:0] p);
		rst_n = 1'h0;
		pins = p;
		wait_clk(5);
		chk("mode", 1'h0, serial_mode);
		chk("link", 16'h0, {1'h0, in_boost_hi, src_sel, out_emph, out_term_en, out_drive_en, out_cur_hi});
		chk("iterm", 16'h0, in_term_off);
		// system holds reset high in normal operation
		rst_n = 1'h1;
		wait_clk(60);
	endtask : do_reset
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	initial begin
		cyc = 0;
		forever begin
			@(posedge clk);
			cyc++;
			if (cyc == 30000) begin
				mismatches++;
				final_report();
			end
		end
	end

	initial begin
		mismatches = 0;
		checks = 0;
		rst_n = 1'h0;
		seed = lfsr(16'h002a);
		strap = seed[2:0];
		v = 8'h08;
		pins = v;
		// outputs held off until a termination is chosen
		do_reset(v);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			v = pin_rand(seed, i[2:0]);
			pins = v;
			wait_clk(40);
			chk_pins(v);
		end
		$display("test parallel done");
		for (int k = 1; k < 9; k++) begin
			a = (k < 8) ? {4'h9, strap ^ k[2:0]} : {4'h1, strap};
			mst.wr(a, REG_TX, 1, 24'hff, ok);
			chk("nack", 1'h0, ok);
			chk("mode", 1'h0, serial_mode);
		end
		wait_clk(40);
		chk_pins(v);
		$display("test foreign address done");
		a = {ADDR_HI, strap};
		seed = lfsr(seed);
		tx = {seed[7:0], seed[15:8], seed[11:4]};
		mst.wr(a, REG_BOOST, 3, tx, ok);
		chk("ack", 1'h1, ok);
		chk("mode", 1'h1, serial_mode);
		pins = ~v;
		wait_clk(40);
		chk("src", {14'h0, v[1:0]}, {14'h0, src_sel});
		chk("boost", {8'h0, tx[7:0]}, {8'h0, in_boost_hi});
		chk("oterm", tx[8], out_term_en);
		chk("cur", tx[9], out_cur_hi);
		chk("emph", tx[11:10], out_emph);
		chk("drive", tx[16], out_drive_en);
		mst.rd(a, REG_BOOST, rdat, ok);
		chk("rack", 1'h1, ok);
		chk("rdata", {8'h0, tx[7:0]}, {8'h0, rdat});
		$display("test serial takeover done");
		mask = lfsr(seed) | 16'h0001;
		mst.wr(a, REG_PULSE_LO, 2, {8'h0, mask}, ok);
		wait_clk(40);
		chk("iterm", 16'h0, in_term_off);
		ns = v[1:0] ^ 2'h2;
		mst.wr(a, REG_SRC, 1, {22'h0, ns}, ok);
		wait_clk(20);
		chk("src", {14'h0, ns}, {14'h0, src_sel});
		chk("iterm", mask, in_term_off);
		wait_clk(TC);
		chk("iterm", 16'h0, in_term_off);
		$display("test termination pulse done");
		seed = lfsr(seed);
		v = pin_rand(seed, seed[10:8]);
		do_reset(v);
		chk_pins(v);
		chk("mode", 1'h0, serial_mode);
		$display("test mid-run reset done");
		final_report();
	end
endmodule : video_switch_config_control_tb
